// ==== design/dcc_safeload.sv ====
`timescale 1ns/100ps
// walks the five safeload slots, one per cycle, strobing only written ones
module dcc_safeload (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic start_in,
   input wire logic [4:0] pending_in,
   output logic busy_out,
   output logic load_out,
   output logic [2:0] slot_out,
   output logic done_out
);
   typedef enum logic {SL_IDLE, SL_WALK} dcc_sl_state_type;

   dcc_sl_state_type state;
   logic [2:0] slot;
   logic [4:0] snap;
   // the start bit still reads high in the done cycle; without this gate the walk would relaunch
   wire take = (state == SL_IDLE) && start_in && !done_out;
   wire last = (state == SL_WALK) && (slot == dcc_pkg::SAFELOAD_LAST_SLOT);

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state <= SL_IDLE;
         slot <= 3'h0;
         snap <= 5'h00;
         load_out <= 1'b0;
         slot_out <= 3'h0;
         done_out <= 1'b0;
         busy_out <= 1'b0;
      end else begin
         load_out <= (state == SL_WALK) && snap[slot];
         slot_out <= slot;
         done_out <= last;
         case (state)
            SL_IDLE: begin
               slot <= 3'h0;
               if (take) begin
                  snap <= pending_in;
                  state <= SL_WALK;
                  busy_out <= 1'b1;
               end
            end
            SL_WALK: begin
               slot <= slot + 3'h1;
               // five cycles total keeps the walk far inside one word clock
               if (last) begin
                  state <= SL_IDLE;
                  busy_out <= 1'b0;
               end
            end
            default: begin
               state <= SL_IDLE;
               busy_out <= 1'b0;
            end
         endcase
      end
   end

   sequence s_launch;
      take;
   endsequence
   sequence s_walk;
      busy_out [*5] ##1 !busy_out;
   endsequence

   a_walk_bounded: assert property (@(posedge clk_in) disable iff (!rst_b_in) s_launch |=> s_walk)
      else $error("safeload walk did not take five cycles");
   a_skip_unwritten: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      load_out |-> snap[slot_out])
      else $error("safeload slot moved without a write");
endmodule

// ==== design/dcc_top.sv ====
`timescale 1ns/100ps
module dcc_top #(
   parameter logic [22:0] DEBOUNCE_A_CYCLES = 23'(dcc_pkg::DEBOUNCE_A_CYCLES),
   parameter logic [22:0] DEBOUNCE_B_CYCLES = 23'(dcc_pkg::DEBOUNCE_B_CYCLES),
   parameter logic [22:0] DEBOUNCE_C_CYCLES = 23'(dcc_pkg::DEBOUNCE_C_CYCLES),
   parameter logic [22:0] DEBOUNCE_D_CYCLES = 23'(dcc_pkg::DEBOUNCE_D_CYCLES)
) (
   input wire logic clk_in,
   input wire logic rst_b_in,
   // control-port register access
   input wire logic [11:0] ctl_addr_in,
   input wire logic ctl_wr_in,
   input wire logic ctl_rd_in,
   input wire logic [15:0] ctl_wdata_in,
   output logic [23:0] ctl_rdata_out,
   output logic ctl_rvalid_out,
   // core execution taps
   input wire dcc_pkg::dcc_step_type core_step_in,
   input wire dcc_pkg::dcc_core_ops_type core_ops_in,
   // safeload pair bookkeeping kept by the safeload registers
   input wire logic [4:0] safeload_pending_in,
   output logic safeload_load_out,
   output logic [2:0] safeload_slot_out,
   output logic safeload_pending_clear_out,
   // controls toward the rest of the device
   output logic [22:0] gpio_debounce_cycles_out,
   output logic aux_adc_port_write_enable_out,
   output logic gpio_setting_port_write_enable_out,
   output logic interface_reg_port_write_enable_out,
   output logic adc_mute_out,
   output logic dac_mute_out,
   output logic core_clear_out,
   output logic [9:0] instructions_per_sample_out,
   output logic [2:0] converter_rate_mult_out
);

   // ---------------------------------------------------------------- functions
   function automatic logic [27:0] pick_source(input dcc_pkg::dcc_core_ops_type ops, input logic [1:0] sel);
      logic [27:0] word;
      word = ops.mult_x;
      case (sel)
         dcc_pkg::SRC_MULT_X: word = ops.mult_x;
         dcc_pkg::SRC_MULT_Y: word = ops.mult_y;
         dcc_pkg::SRC_MAC: word = ops.mac;
         dcc_pkg::SRC_ACCUM: word = ops.accum;
         default: word = ops.mult_x;
      endcase
      return word;
   endfunction

   // sign is kept, the low bits are simply truncated, not rounded
   function automatic logic [23:0] to_capture(input logic [27:0] word);
      return word[27:dcc_pkg::CAP_DROP_BITS];
   endfunction

   function automatic logic step_hit(input dcc_pkg::dcc_step_type stp, input dcc_pkg::dcc_capture_setup_type su);
      return stp.valid && (stp.pc == su.step);
   endfunction

   function automatic logic [22:0] debounce_cycles(input logic [1:0] gd);
      logic [22:0] cyc;
      cyc = DEBOUNCE_A_CYCLES;
      case (gd)
         2'h0: cyc = DEBOUNCE_A_CYCLES;
         2'h1: cyc = DEBOUNCE_B_CYCLES;
         2'h2: cyc = DEBOUNCE_C_CYCLES;
         2'h3: cyc = DEBOUNCE_D_CYCLES;
         default: cyc = DEBOUNCE_A_CYCLES;
      endcase
      return cyc;
   endfunction

   function automatic logic [9:0] rate_ips(input logic [1:0] sr);
      logic [9:0] ips;
      ips = dcc_pkg::IPS_1X;
      case (sr)
         dcc_pkg::RATE_1X: ips = dcc_pkg::IPS_1X;
         dcc_pkg::RATE_2X: ips = dcc_pkg::IPS_2X;
         dcc_pkg::RATE_4X: ips = dcc_pkg::IPS_4X;
         default: ips = dcc_pkg::IPS_1X;
      endcase
      return ips;
   endfunction

   function automatic logic [2:0] rate_mult(input logic [1:0] sr);
      logic [2:0] m;
      m = dcc_pkg::MULT_1X;
      case (sr)
         dcc_pkg::RATE_1X: m = dcc_pkg::MULT_1X;
         dcc_pkg::RATE_2X: m = dcc_pkg::MULT_2X;
         dcc_pkg::RATE_4X: m = dcc_pkg::MULT_4X;
         default: m = dcc_pkg::MULT_1X;
      endcase
      return m;
   endfunction

   // ---------------------------------------------------------------- state
   dcc_pkg::dcc_capture_setup_type cap_setup [2];
   logic [23:0] cap_value [2];
   logic [1:0] gd_field;
   logic [1:0] rate_field;
   logic start_bit;
   logic sl_busy;
   logic sl_done;

   // ---------------------------------------------------------------- decode
   wire wr_cap0 = ctl_wr_in && (ctl_addr_in == dcc_pkg::ADDR_CAPTURE_0);
   wire wr_cap1 = ctl_wr_in && (ctl_addr_in == dcc_pkg::ADDR_CAPTURE_1);
   wire wr_ctl = ctl_wr_in && (ctl_addr_in == dcc_pkg::ADDR_CORE_CONTROL);
   wire rd_cap0 = ctl_rd_in && (ctl_addr_in == dcc_pkg::ADDR_CAPTURE_0);
   wire rd_cap1 = ctl_rd_in && (ctl_addr_in == dcc_pkg::ADDR_CAPTURE_1);
   wire rd_ctl = ctl_rd_in && (ctl_addr_in == dcc_pkg::ADDR_CORE_CONTROL);
   wire rd_hit = rd_cap0 || rd_cap1 || rd_ctl;
   wire [1:0] wr_cap = {wr_cap1, wr_cap0};

   wire [1:0] w_gd = ctl_wdata_in[dcc_pkg::CC_DEBOUNCE_LSB +: 2];
   wire [1:0] w_rate = ctl_wdata_in[dcc_pkg::CC_RATE_LSB +: 2];
   wire w_start = ctl_wdata_in[dcc_pkg::CC_START_SAFELOAD];

   wire [1:0] hit = {step_hit(core_step_in, cap_setup[1]), step_hit(core_step_in, cap_setup[0])};

   wire [15:0] ctl_readback = {2'h0, gd_field, 3'h0, aux_adc_port_write_enable_out,
      gpio_setting_port_write_enable_out, interface_reg_port_write_enable_out, start_bit,
      ~adc_mute_out, ~dac_mute_out, ~core_clear_out, rate_field};

   // reads only select, so a capture read never disturbs setup or core
   wire [23:0] next_rdata = rd_cap0 ? cap_value[0] :
      rd_cap1 ? cap_value[1] :
      rd_ctl ? {8'h00, ctl_readback} : 24'h000000;

   // hardware clear loses to a fresh software set in the same cycle
   wire next_start = (wr_ctl && w_start) || (start_bit && !sl_done);

   // ---------------------------------------------------------------- capture channels
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         for (int i = 0; i < 2; i++) begin
            cap_setup[i] <= dcc_pkg::CAPTURE_SETUP_RESET[11:0];
            cap_value[i] <= dcc_pkg::CAPTURE_VALUE_RESET;
         end
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (wr_cap[i]) begin
               cap_setup[i] <= ctl_wdata_in[11:0];
            end
            if (hit[i]) begin
               cap_value[i] <= to_capture(pick_source(core_ops_in, cap_setup[i].src));
            end
         end
      end
   end

   // ---------------------------------------------------------------- core control
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         gd_field <= dcc_pkg::CORE_CONTROL_RESET[dcc_pkg::CC_DEBOUNCE_LSB +: 2];
         rate_field <= dcc_pkg::CORE_CONTROL_RESET[dcc_pkg::CC_RATE_LSB +: 2];
         aux_adc_port_write_enable_out <= dcc_pkg::CORE_CONTROL_RESET[dcc_pkg::CC_AUX_PW];
         gpio_setting_port_write_enable_out <= dcc_pkg::CORE_CONTROL_RESET[dcc_pkg::CC_GPIO_PW];
         interface_reg_port_write_enable_out <= dcc_pkg::CORE_CONTROL_RESET[dcc_pkg::CC_IFACE_PW];
         adc_mute_out <= ~dcc_pkg::CORE_CONTROL_RESET[dcc_pkg::CC_ADC_UNMUTE];
         dac_mute_out <= ~dcc_pkg::CORE_CONTROL_RESET[dcc_pkg::CC_DAC_UNMUTE];
         core_clear_out <= ~dcc_pkg::CORE_CONTROL_RESET[dcc_pkg::CC_CORE_RUN];
         gpio_debounce_cycles_out <= DEBOUNCE_A_CYCLES;
         instructions_per_sample_out <= dcc_pkg::IPS_1X;
         converter_rate_mult_out <= dcc_pkg::MULT_1X;
      end else if (wr_ctl) begin
         gd_field <= w_gd;
         rate_field <= w_rate;
         gpio_debounce_cycles_out <= debounce_cycles(w_gd);
         aux_adc_port_write_enable_out <= ctl_wdata_in[dcc_pkg::CC_AUX_PW];
         gpio_setting_port_write_enable_out <= ctl_wdata_in[dcc_pkg::CC_GPIO_PW];
         interface_reg_port_write_enable_out <= ctl_wdata_in[dcc_pkg::CC_IFACE_PW];
         adc_mute_out <= ~ctl_wdata_in[dcc_pkg::CC_ADC_UNMUTE];
         dac_mute_out <= ~ctl_wdata_in[dcc_pkg::CC_DAC_UNMUTE];
         core_clear_out <= ~ctl_wdata_in[dcc_pkg::CC_CORE_RUN];
         instructions_per_sample_out <= rate_ips(w_rate);
         converter_rate_mult_out <= rate_mult(w_rate);
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         start_bit <= dcc_pkg::CORE_CONTROL_RESET[dcc_pkg::CC_START_SAFELOAD];
         ctl_rdata_out <= 24'h000000;
         ctl_rvalid_out <= 1'b0;
         safeload_pending_clear_out <= 1'b0;
      end else begin
         start_bit <= next_start;
         ctl_rdata_out <= next_rdata;
         ctl_rvalid_out <= rd_hit;
         safeload_pending_clear_out <= sl_done;
      end
   end

   // ---------------------------------------------------------------- safeload walk
   dcc_safeload u_safeload (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .start_in(start_bit),
      .pending_in(safeload_pending_in),
      .busy_out(sl_busy),
      .load_out(safeload_load_out),
      .slot_out(safeload_slot_out),
      .done_out(sl_done)
   );

   // ---------------------------------------------------------------- checks
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_b_in);

   sequence s_ctl_write(logic [15:0] mask, logic [15:0] value);
      wr_ctl && ((ctl_wdata_in & mask) == value);
   endsequence

   a_capture_on_step: assert property (hit[0] |=>
      cap_value[0] == $past(to_capture(pick_source(core_ops_in, cap_setup[0].src))))
      else $error("channel 0 did not capture on its step");
   a_capture_holds: assert property (!hit[1] |=> $stable(cap_value[1]))
      else $error("channel 1 changed without a step match");
   a_setup_layout: assert property (wr_cap1 && !wr_cap0 |=>
      cap_setup[1].step == $past(ctl_wdata_in[11:2]) && cap_setup[1].src == $past(ctl_wdata_in[1:0]))
      else $error("capture setup fields misplaced");
   a_read_capture: assert property (rd_cap0 |=> ctl_rvalid_out && ctl_rdata_out == $past(cap_value[0]))
      else $error("capture read returned wrong value");
   a_debounce_map: assert property (s_ctl_write(16'h3000, 16'h3000) |=>
      gpio_debounce_cycles_out == DEBOUNCE_D_CYCLES)
      else $error("debounce setting 11 not mapped to shortest time");
   a_port_write_bits: assert property (wr_ctl |=>
      {aux_adc_port_write_enable_out, gpio_setting_port_write_enable_out,
       interface_reg_port_write_enable_out} == $past(ctl_wdata_in[8:6]))
      else $error("port write enables not taken from write");
   a_mute_low_active: assert property (s_ctl_write(16'h001c, 16'h0000) |=>
      adc_mute_out && dac_mute_out && core_clear_out)
      else $error("zero unmute or run bits did not mute and clear");
   a_rate_map: assert property (s_ctl_write(16'h0003, 16'h0002) |=>
      instructions_per_sample_out == dcc_pkg::IPS_4X && converter_rate_mult_out == dcc_pkg::MULT_4X)
      else $error("quadruple rate setting decoded wrongly");
   // a start written in the done cycle legally rearms, so only an unopposed done must clear
   a_start_self_clear: assert property (sl_done && !(wr_ctl && w_start) |=> !start_bit)
      else $error("safeload start bit did not clear itself");
   a_start_set_wins: assert property (sl_done && wr_ctl && w_start |=> start_bit)
      else $error("software set lost against hardware clear");

endmodule

// ==== dv/dcc_host_model.sv ====
`timescale 1ns/100ps
// host on the control port: one-cycle strobes, lines toggled when released
module dcc_host_model (
   input wire logic clk_in,
   output logic [11:0] ctl_addr_out,
   output logic ctl_wr_out,
   output logic ctl_rd_out,
   output logic [15:0] ctl_wdata_out,
   input wire logic [23:0] ctl_rdata_in,
   input wire logic ctl_rvalid_in
);
   initial begin
      ctl_addr_out = 12'h000;
      ctl_wr_out = 1'b0;
      ctl_rd_out = 1'b0;
      ctl_wdata_out = 16'h0000;
   end
   // stale address or data must never look like a fresh request
   task automatic idle();
      ctl_wr_out <= 1'b0;
      ctl_rd_out <= 1'b0;
      ctl_addr_out <= ~ctl_addr_out;
      ctl_wdata_out <= ~ctl_wdata_out;
   endtask
   task automatic wr(input logic [11:0] addr, input logic [15:0] data);
      @(posedge clk_in);
      ctl_addr_out <= addr;
      ctl_wdata_out <= data;
      ctl_wr_out <= 1'b1;
      @(posedge clk_in);
      idle();
   endtask
   task automatic rd(input logic [11:0] addr, output logic [23:0] data, output logic valid);
      @(posedge clk_in);
      ctl_addr_out <= addr;
      ctl_rd_out <= 1'b1;
      @(posedge clk_in);
      idle();
      #1;
      data = ctl_rdata_in;
      valid = ctl_rvalid_in;
   endtask
endmodule

// ==== dv/tb.sv ====
`timescale 1ns/100ps
module tb;
   logic clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic [11:0] ctl_addr;
   logic ctl_wr, ctl_rd, ctl_rvalid, clr_seen, v;
   logic [15:0] ctl_wdata, w;
   logic [23:0] ctl_rdata, d;
   dcc_pkg::dcc_step_type core_step_in = '0;
   dcc_pkg::dcc_core_ops_type core_ops_in = '0;
   logic [4:0] safeload_pending_in = 5'h00;
   logic [4:0] load_mask = 5'h00;
   logic sl_arm = 1'b0;
   logic [4:0] sl_pat = 5'h00;
   logic safeload_load_out, safeload_pending_clear_out;
   logic [2:0] safeload_slot_out;
   logic [22:0] gpio_debounce_cycles_out;
   logic aux_pw, gpio_pw, iface_pw, adc_mute_out, dac_mute_out, core_clear_out;
   logic [9:0] ips_out;
   logic [2:0] mult_out;
   logic [22:0] db_tab [4] = '{23'h0000c8, 23'h000190, 23'h000064, 23'h000032};
   logic [9:0] ips_tab [4] = '{10'h200, 10'h100, 10'h080, 10'h200};
   logic [2:0] mult_tab [4] = '{3'h1, 3'h2, 3'h4, 3'h1};
   logic [9:0] steps [4] = '{10'h3ff, 10'h000, 10'h001, 10'h1ff};
   logic [4:0] pats [3] = '{5'h15, 5'h0a, 5'h00};
   logic [23:0] prev [2] = '{24'h000000, 24'h000000};
   logic [23:0] exp_v;
   logic [11:0] addr;
   int err_total = 0;
   int n_checks = 0;
   int cyc = 0;

   always #4 clk_in = ~clk_in;

   dcc_top #(.DEBOUNCE_A_CYCLES(23'h0000c8), .DEBOUNCE_B_CYCLES(23'h000190),
      .DEBOUNCE_C_CYCLES(23'h000064), .DEBOUNCE_D_CYCLES(23'h000032)) u_dut (
      .clk_in(clk_in), .rst_b_in(rst_b_in), .ctl_addr_in(ctl_addr), .ctl_wr_in(ctl_wr),
      .ctl_rd_in(ctl_rd), .ctl_wdata_in(ctl_wdata), .ctl_rdata_out(ctl_rdata),
      .ctl_rvalid_out(ctl_rvalid), .core_step_in(core_step_in), .core_ops_in(core_ops_in),
      .safeload_pending_in(safeload_pending_in), .safeload_load_out(safeload_load_out),
      .safeload_slot_out(safeload_slot_out), .safeload_pending_clear_out(safeload_pending_clear_out),
      .gpio_debounce_cycles_out(gpio_debounce_cycles_out), .aux_adc_port_write_enable_out(aux_pw),
      .gpio_setting_port_write_enable_out(gpio_pw), .interface_reg_port_write_enable_out(iface_pw),
      .adc_mute_out(adc_mute_out), .dac_mute_out(dac_mute_out), .core_clear_out(core_clear_out),
      .instructions_per_sample_out(ips_out), .converter_rate_mult_out(mult_out));

   dcc_host_model u_host (
      .clk_in(clk_in), .ctl_addr_out(ctl_addr), .ctl_wr_out(ctl_wr), .ctl_rd_out(ctl_rd),
      .ctl_wdata_out(ctl_wdata), .ctl_rdata_in(ctl_rdata), .ctl_rvalid_in(ctl_rvalid));

   // outside keeper of the safeload pending marks
   always @(posedge clk_in) begin
      if (sl_arm) begin
         safeload_pending_in <= sl_pat;
         load_mask <= 5'h00;
         clr_seen <= 1'b0;
      end else begin
         if (safeload_load_out) begin
            load_mask[safeload_slot_out] <= 1'b1;
         end
         if (safeload_pending_clear_out) begin
            safeload_pending_in <= 5'h00;
            clr_seen <= 1'b1;
         end
      end
   end

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         close_out();
      end
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic rd_chk(input string what, input logic [11:0] a, input logic [23:0] exp);
      logic [23:0] rd_d;
      logic rd_v;
      u_host.rd(a, rd_d, rd_v);
      chk({what, " valid"}, 32'(rd_v), 32'h1);
      chk(what, 32'(rd_d), 32'(exp));
   endtask

   // reserved bits read back as zero, start bit assumed idle
   task automatic cc_chk(input logic [15:0] cw);
      #1;
      chk("debounce", 32'(gpio_debounce_cycles_out), 32'(db_tab[cw[13:12]]));
      chk("aux pw", 32'(aux_pw), 32'(cw[8]));
      chk("gpio pw", 32'(gpio_pw), 32'(cw[7]));
      chk("iface pw", 32'(iface_pw), 32'(cw[6]));
      chk("adc mute", 32'(adc_mute_out), 32'(!cw[4]));
      chk("dac mute", 32'(dac_mute_out), 32'(!cw[3]));
      chk("core clear", 32'(core_clear_out), 32'(!cw[2]));
      chk("ips", 32'(ips_out), 32'(ips_tab[cw[1:0]]));
      chk("rate mult", 32'(mult_out), 32'(mult_tab[cw[1:0]]));
      rd_chk("core ctl", dcc_pkg::ADDR_CORE_CONTROL, 24'(cw & 16'h31df));
   endtask

   function automatic logic [27:0] opv(input int i, input int j);
      return {4'(8 + j), 4'(i), 16'hc35a, 4'hf};
   endfunction

   initial begin
      repeat (12) @(posedge clk_in);
      rst_b_in <= 1'b1;
      cc_chk(16'h0000);
      rd_chk("cap0 reset", dcc_pkg::ADDR_CAPTURE_0, 24'h000000);
      rd_chk("cap1 reset", dcc_pkg::ADDR_CAPTURE_1, 24'h000000);
      for (int i = 0; i < 4; i++) begin
         w = {2'h3, 2'(i), 3'h7, i[0], i[1], !i[0], 1'b0, i[0], i[1], !i[1], 2'(i)};
         u_host.wr(dcc_pkg::ADDR_CORE_CONTROL, w);
         cc_chk(w);
      end
      for (int i = 0; i < 4; i++) begin
         addr = (i % 2) ? dcc_pkg::ADDR_CAPTURE_1 : dcc_pkg::ADDR_CAPTURE_0;
         @(posedge clk_in);
         core_ops_in <= {opv(i, 0), opv(i, 1), opv(i, 2), opv(i, 3)};
         core_step_in <= {1'b0, steps[i]};
         u_host.wr(addr, {4'h0, steps[i], 2'(i)});
         rd_chk("cap held", addr, prev[i % 2]);
         @(posedge clk_in);
         core_step_in <= {1'b1, steps[i] ^ 10'h200};
         @(posedge clk_in);
         core_step_in <= {1'b1, steps[i]};
         @(posedge clk_in);
         core_step_in <= {1'b0, steps[i]};
         core_ops_in <= ~core_ops_in;
         exp_v = 24'(opv(i, i) >> dcc_pkg::CAP_DROP_BITS);
         rd_chk("cap value", addr, exp_v);
         rd_chk("cap reread", addr, exp_v);
         prev[i % 2] = exp_v;
      end
      for (int p = 0; p < 3; p++) begin
         @(posedge clk_in);
         sl_pat <= pats[p];
         sl_arm <= 1'b1;
         @(posedge clk_in);
         sl_arm <= 1'b0;
         u_host.wr(dcc_pkg::ADDR_CORE_CONTROL, 16'h0024);
         rd_chk("start busy", dcc_pkg::ADDR_CORE_CONTROL, 24'h000024);
         for (int n = 0; n < 12 && clr_seen !== 1'b1; n++) @(posedge clk_in);
         #1;
         chk("walk done", 32'(clr_seen), 32'h1);
         chk("slots moved", 32'(load_mask), 32'(pats[p]));
         rd_chk("start cleared", dcc_pkg::ADDR_CORE_CONTROL, 24'h000004);
      end
      // the fourth write lands in the done cycle of the first walk and must rearm it
      u_host.wr(dcc_pkg::ADDR_CORE_CONTROL, 16'h0024);
      @(posedge clk_in);
      for (int k = 0; k < 3; k++) begin
         u_host.wr(dcc_pkg::ADDR_CORE_CONTROL, 16'h0024);
      end
      rd_chk("start rearmed", dcc_pkg::ADDR_CORE_CONTROL, 24'h000024);
      repeat (8) @(posedge clk_in);
      rd_chk("rearm cleared", dcc_pkg::ADDR_CORE_CONTROL, 24'h000004);
      u_host.wr(12'h81d, 16'hffff);
      u_host.rd(12'h81d, d, v);
      chk("unmapped rvalid", 32'(v), 32'h0);
      rd_chk("ctl kept", dcc_pkg::ADDR_CORE_CONTROL, 24'h000004);
      @(posedge clk_in);
      rst_b_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      rst_b_in <= 1'b1;
      cc_chk(16'h0000);
      rd_chk("cap0 cleared", dcc_pkg::ADDR_CAPTURE_0, 24'h000000);
      close_out();
   end
endmodule

// ==== pkg/dcc_pkg.sv ====
package dcc_pkg;

   // control-port addresses of this bank
   localparam logic [11:0] ADDR_CAPTURE_0 = 12'h81a;
   localparam logic [11:0] ADDR_CAPTURE_1 = 12'h81b;
   localparam logic [11:0] ADDR_CORE_CONTROL = 12'h81c;

   // reset values
   localparam logic [15:0] CORE_CONTROL_RESET = 16'h0000;
   localparam logic [15:0] CAPTURE_SETUP_RESET = 16'h0000;
   localparam logic [23:0] CAPTURE_VALUE_RESET = 24'h000000;

   // core control field positions
   localparam int CC_RATE_LSB = 0;
   localparam int CC_CORE_RUN = 2;
   localparam int CC_DAC_UNMUTE = 3;
   localparam int CC_ADC_UNMUTE = 4;
   localparam int CC_START_SAFELOAD = 5;
   localparam int CC_IFACE_PW = 6;
   localparam int CC_GPIO_PW = 7;
   localparam int CC_AUX_PW = 8;
   localparam int CC_DEBOUNCE_LSB = 12;

   // capture setup field positions and low bits dropped on capture
   localparam int CAP_SRC_LSB = 0;
   localparam int CAP_STEP_LSB = 2;
   localparam int CAP_DROP_BITS = 4;

   // capture source codes
   localparam logic [1:0] SRC_MULT_X = 2'h0;
   localparam logic [1:0] SRC_MULT_Y = 2'h1;
   localparam logic [1:0] SRC_MAC = 2'h2;
   localparam logic [1:0] SRC_ACCUM = 2'h3;

   // instruction rate codes and their counts
   localparam logic [1:0] RATE_1X = 2'h0;
   localparam logic [1:0] RATE_2X = 2'h1;
   localparam logic [1:0] RATE_4X = 2'h2;
   localparam logic [9:0] IPS_1X = 10'h200;
   localparam logic [9:0] IPS_2X = 10'h100;
   localparam logic [9:0] IPS_4X = 10'h080;
   localparam logic [2:0] MULT_1X = 3'h1;
   localparam logic [2:0] MULT_2X = 3'h2;
   localparam logic [2:0] MULT_4X = 3'h4;

   // debounce times and their cycle counts at the core clock
   localparam int CLK_KHZ = 125000;
   localparam int DEBOUNCE_A_MS = 20;
   localparam int DEBOUNCE_B_MS = 40;
   localparam int DEBOUNCE_C_MS = 10;
   localparam int DEBOUNCE_D_MS = 5;
   localparam int DEBOUNCE_A_CYCLES = DEBOUNCE_A_MS * CLK_KHZ;
   localparam int DEBOUNCE_B_CYCLES = DEBOUNCE_B_MS * CLK_KHZ;
   localparam int DEBOUNCE_C_CYCLES = DEBOUNCE_C_MS * CLK_KHZ;
   localparam int DEBOUNCE_D_CYCLES = DEBOUNCE_D_MS * CLK_KHZ;

   localparam int SAFELOAD_SLOTS = 5;
   localparam logic [2:0] SAFELOAD_LAST_SLOT = 3'h4;

   typedef struct packed {
      logic [9:0] step;
      logic [1:0] src;
   } dcc_capture_setup_type;

   typedef struct packed {
      logic [27:0] mult_x;
      logic [27:0] mult_y;
      logic [27:0] mac;
      logic [27:0] accum;
   } dcc_core_ops_type;

   typedef struct packed {
      logic valid;
      logic [9:0] pc;
   } dcc_step_type;

endpackage
